// file: inc/dac_ctrl_consts.vh
// Purpose: Shared constants for the dual converter control block.
// Assumes: Byte-wide special function register space on the core clock.
// Notes: Definitions only; include by bare name.
`ifndef DAC_CTRL_CONSTS_VH
`define DAC_CTRL_CONSTS_VH

// Register addresses in special function register space
`define ADDR_CH0_LOW 8'hf9
`define ADDR_CH0_HIGH 8'hfa
`define ADDR_CH1_LOW 8'hfb
`define ADDR_CH1_HIGH 8'hfc
`define ADDR_CONTROL 8'hfd

// Power-on values
`define RST_CODE_BYTE 8'h00
`define RST_CONTROL 8'h04

// Control register field positions
`define BIT_MODE8 7
`define BIT_CH1_SPAN 6
`define BIT_CH0_SPAN 5
`define BIT_CH1_FZN 4
`define BIT_CH0_FZN 3
`define BIT_SYNC 2
`define BIT_CH1_PWR 1
`define BIT_CH0_PWR 0

// Data widths and fills
`define BYTE_W 8
`define CODE_W 12
`define NIBBLE_MSB 3
`define CODE_PAD 4'h0
`define ZERO_CODE 12'h000
`define READ_IDLE 8'h00
`define CHAN_COUNT 2

`endif

// file: hw/sfr_byte_reg.v
// Purpose: One byte-wide software register with a fixed power-on value.
// Assumes: Write strobe and data come from logic on the same clock.
// Notes: Stores all eight bits; consumers decide which bits matter.
`timescale 1ns/1ps
`include "dac_ctrl_consts.vh"

module sfr_byte_reg #(
    parameter [7:0] RESET_VAL = `RST_CODE_BYTE
) (
    input wire clk,
    input wire rst_n,
    input wire wr_en,
    input wire [`BYTE_W-1:0] wdata,
    output reg [`BYTE_W-1:0] q_ff
);

    // Plain storage; the reset value is a constant parameter only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= RESET_VAL;
        end else if (wr_en) begin
            q_ff <= wdata;
        end
    end

endmodule

// file: hw/chan_code_path.v
// Purpose: Holds the code a converter channel is currently driving.
// Assumes: Byte sources already reflect a write landing in this cycle.
// Notes: The held bytes may change freely while this code stays put.
`timescale 1ns/1ps
`include "dac_ctrl_consts.vh"

module chan_code_path (
    input wire clk,
    input wire rst_n,
    input wire load,
    input wire mode8,
    input wire [`BYTE_W-1:0] low_byte,
    input wire [`BYTE_W-1:0] high_byte,
    output reg [`CODE_W-1:0] code_ff
);

    reg [`CODE_W-1:0] nxt_code;

    // Assemble the code; in 8-bit mode the high byte takes no part and the
    // low byte is left aligned so both modes span the full range
    always @* begin
        if (mode8) begin
            nxt_code = {low_byte, `CODE_PAD};
        end else begin
            nxt_code = {high_byte[`NIBBLE_MSB:0], low_byte};
        end
    end

    // Active code register, loaded only on an update event
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_ff <= `ZERO_CODE;
        end else if (load) begin
            code_ff <= nxt_code;
        end
    end

endmodule

// file: hw/dual_dac_ctrl.v
// Purpose: Control and update logic for two 12-bit voltage output converters.
// Assumes: Core drives SFR address, data and one-cycle strobes on SYS_CLK.
// Notes: Analog string, buffers and reference live outside this block.
`timescale 1ns/1ps
`include "dac_ctrl_consts.vh"

module dual_dac_ctrl (
    input wire SYS_CLK,
    input wire RST_N,
    input wire [7:0] SFR_ADDR,
    input wire [`BYTE_W-1:0] SFR_WDATA,
    input wire SFR_WR,
    input wire SFR_RD,
    output wire [`BYTE_W-1:0] SFR_RDATA,
    output wire SFR_RD_HIT,
    output wire [`CODE_W-1:0] CHAN0_CODE,
    output wire [`CODE_W-1:0] CHAN1_CODE,
    output wire CHAN0_SPAN_SELECT,
    output wire CHAN1_SPAN_SELECT,
    output wire CHAN0_POWER_ON,
    output wire CHAN1_POWER_ON,
    output wire CHAN0_OUT_EN,
    output wire CHAN1_OUT_EN,
    output wire CHAN0_FORCE_ZERO_N,
    output wire CHAN1_FORCE_ZERO_N
);

    // Register index decode, shared by the write and read paths
    localparam [2:0] IDX_CH0_LOW = 3'h0;
    localparam [2:0] IDX_CH0_HIGH = 3'h1;
    localparam [2:0] IDX_CH1_LOW = 3'h2;
    localparam [2:0] IDX_CH1_HIGH = 3'h3;
    localparam [2:0] IDX_CONTROL = 3'h4;
    localparam [2:0] IDX_NONE = 3'h7;

    // Maps an SFR address to a register index, IDX_NONE when unmapped
    function [2:0] reg_index;
        input [7:0] addr;
        begin
            if (addr == `ADDR_CH0_LOW) begin
                reg_index = IDX_CH0_LOW;
            end else if (addr == `ADDR_CH0_HIGH) begin
                reg_index = IDX_CH0_HIGH;
            end else if (addr == `ADDR_CH1_LOW) begin
                reg_index = IDX_CH1_LOW;
            end else if (addr == `ADDR_CH1_HIGH) begin
                reg_index = IDX_CH1_HIGH;
            end else if (addr == `ADDR_CONTROL) begin
                reg_index = IDX_CONTROL;
            end else begin
                reg_index = IDX_NONE;
            end
        end
    endfunction

    // Decoded register index and one write strobe per register
    wire [2:0] wr_idx;
    wire [2:0] rd_idx;
    wire wr_ch0_low;
    wire wr_ch0_high;
    wire wr_ch1_low;
    wire wr_ch1_high;
    wire wr_control;

    // Write strobes per register; core inputs share our clock, no synchroniser
    assign wr_idx = reg_index(SFR_ADDR);
    assign rd_idx = reg_index(SFR_ADDR);
    assign wr_ch0_low = SFR_WR && (wr_idx == IDX_CH0_LOW);
    assign wr_ch0_high = SFR_WR && (wr_idx == IDX_CH0_HIGH);
    assign wr_ch1_low = SFR_WR && (wr_idx == IDX_CH1_LOW);
    assign wr_ch1_high = SFR_WR && (wr_idx == IDX_CH1_HIGH);
    assign wr_control = SFR_WR && (wr_idx == IDX_CONTROL);

    // Stored register bytes, read back whole
    wire [`BYTE_W-1:0] ch0_low_q;
    wire [`BYTE_W-1:0] ch0_high_q;
    wire [`BYTE_W-1:0] ch1_low_q;
    wire [`BYTE_W-1:0] ch1_high_q;
    wire [`BYTE_W-1:0] control_q;

    // Data bytes power up at 00, the control byte at 04: sync set, all off
    sfr_byte_reg #(.RESET_VAL(`RST_CODE_BYTE)) u_ch0_low (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .wr_en(wr_ch0_low),
        .wdata(SFR_WDATA),
        .q_ff(ch0_low_q)
    );

    sfr_byte_reg #(.RESET_VAL(`RST_CODE_BYTE)) u_ch0_high (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .wr_en(wr_ch0_high),
        .wdata(SFR_WDATA),
        .q_ff(ch0_high_q)
    );

    sfr_byte_reg #(.RESET_VAL(`RST_CODE_BYTE)) u_ch1_low (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .wr_en(wr_ch1_low),
        .wdata(SFR_WDATA),
        .q_ff(ch1_low_q)
    );

    sfr_byte_reg #(.RESET_VAL(`RST_CODE_BYTE)) u_ch1_high (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .wr_en(wr_ch1_high),
        .wdata(SFR_WDATA),
        .q_ff(ch1_high_q)
    );

    sfr_byte_reg #(.RESET_VAL(`RST_CONTROL)) u_control (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .wr_en(wr_control),
        .wdata(SFR_WDATA),
        .q_ff(control_q)
    );

    // Update control shared by both channels
    wire sync_now;
    wire sync_rise;
    wire mode8_src;

    // Sync as it stands before any write in this cycle
    assign sync_now = control_q[`BIT_SYNC];

    // A control write that turns sync on releases both held codes together
    assign sync_rise = wr_control && SFR_WDATA[`BIT_SYNC] && !sync_now;

    // Mode taken from the incoming byte when control is written this cycle,
    // so the release uses the mode that software just chose
    assign mode8_src = wr_control ? SFR_WDATA[`BIT_MODE8] : control_q[`BIT_MODE8];

    // Per-channel byte sources, packed for the generate loop below
    wire [`BYTE_W-1:0] low_q [0:`CHAN_COUNT-1];
    wire [`BYTE_W-1:0] high_q [0:`CHAN_COUNT-1];
    wire [`CHAN_COUNT-1:0] low_wr;
    wire [`CHAN_COUNT-1:0] high_wr;

    assign low_q[0] = ch0_low_q;
    assign low_q[1] = ch1_low_q;
    assign high_q[0] = ch0_high_q;
    assign high_q[1] = ch1_high_q;
    assign low_wr = {wr_ch1_low, wr_ch0_low};
    assign high_wr = {wr_ch1_high, wr_ch0_high};

    // Codes held by the two channel paths between update events
    wire [`CODE_W-1:0] active_code [0:`CHAN_COUNT-1];
    wire [`CHAN_COUNT-1:0] chan_load;

    genvar ch;
    generate
        for (ch = 0; ch < `CHAN_COUNT; ch = ch + 1) begin : g_chan
            wire [`BYTE_W-1:0] low_src;
            wire [`BYTE_W-1:0] high_src;

            // Forward a byte landing this cycle so the update sees it
            assign low_src = low_wr[ch] ? SFR_WDATA : low_q[ch];
            assign high_src = high_wr[ch] ? SFR_WDATA : high_q[ch];

            // Immediate update only on the low byte write while sync is set;
            // the high byte write never moves the output, which is why
            // software writes it first in 12-bit mode
            assign chan_load[ch] = (low_wr[ch] && sync_now) || sync_rise;

            // Upper nibble dropped; high byte unused in 8-bit mode
            chan_code_path u_path (
                .clk(SYS_CLK),
                .rst_n(RST_N),
                .load(chan_load[ch]),
                .mode8(mode8_src),
                .low_byte(low_src),
                .high_byte(high_src),
                .code_ff(active_code[ch])
            );
        end
    endgenerate

    // Registered copies of every level the block drives out
    reg [`CODE_W-1:0] chan0_code_ff;
    reg [`CODE_W-1:0] chan1_code_ff;
    reg chan0_span_ff;
    reg chan1_span_ff;
    reg chan0_power_ff;
    reg chan1_power_ff;
    reg chan0_fzn_ff;
    reg chan1_fzn_ff;

    // Output levels at power-on come from the control byte's reset value,
    // so the pins and the register cannot disagree right after reset
    localparam [`BYTE_W-1:0] CTRL_AT_RESET = `RST_CONTROL;

    // Force-zero gate; the clear bit is active low and wins over any code
    function [`CODE_W-1:0] gated_code;
        input keep;
        input [`CODE_W-1:0] code;
        begin
            if (keep) begin
                gated_code = code;
            end else begin
                gated_code = `ZERO_CODE;
            end
        end
    endfunction

    // Output stage: force-zero overrides the code; span and power follow
    // the control byte one cycle after it changes, like the code does
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            chan0_code_ff <= `ZERO_CODE;
            chan1_code_ff <= `ZERO_CODE;
            chan0_span_ff <= CTRL_AT_RESET[`BIT_CH0_SPAN];
            chan1_span_ff <= CTRL_AT_RESET[`BIT_CH1_SPAN];
            chan0_power_ff <= CTRL_AT_RESET[`BIT_CH0_PWR];
            chan1_power_ff <= CTRL_AT_RESET[`BIT_CH1_PWR];
            chan0_fzn_ff <= CTRL_AT_RESET[`BIT_CH0_FZN];
            chan1_fzn_ff <= CTRL_AT_RESET[`BIT_CH1_FZN];
        end else begin
            chan0_code_ff <= gated_code(control_q[`BIT_CH0_FZN], active_code[0]);
            chan1_code_ff <= gated_code(control_q[`BIT_CH1_FZN], active_code[1]);
            chan0_fzn_ff <= control_q[`BIT_CH0_FZN];
            chan1_fzn_ff <= control_q[`BIT_CH1_FZN];
            chan0_span_ff <= control_q[`BIT_CH0_SPAN];
            chan1_span_ff <= control_q[`BIT_CH1_SPAN];
            chan0_power_ff <= control_q[`BIT_CH0_PWR];
            chan1_power_ff <= control_q[`BIT_CH1_PWR];
        end
    end

    // Output enable is the power bit: an off channel leaves its pin floating,
    // so a board wanting 0 V during power transients needs a pulldown
    assign CHAN0_OUT_EN = chan0_power_ff;
    assign CHAN1_OUT_EN = chan1_power_ff;
    assign CHAN0_POWER_ON = chan0_power_ff;
    assign CHAN1_POWER_ON = chan1_power_ff;
    assign CHAN0_SPAN_SELECT = chan0_span_ff;
    assign CHAN1_SPAN_SELECT = chan1_span_ff;
    assign CHAN0_FORCE_ZERO_N = chan0_fzn_ff;
    assign CHAN1_FORCE_ZERO_N = chan1_fzn_ff;
    assign CHAN0_CODE = chan0_code_ff;
    assign CHAN1_CODE = chan1_code_ff;

    // Read answer state, standing for exactly one cycle
    reg [`BYTE_W-1:0] nxt_rdata;
    reg nxt_hit;
    reg [`BYTE_W-1:0] rdata_ff;
    reg rd_hit_ff;

    // Read mux: stored bytes read back whole, unmapped addresses read zero
    always @* begin
        nxt_rdata = `READ_IDLE;
        nxt_hit = 1'b1;
        if (rd_idx == IDX_CH0_LOW) begin
            nxt_rdata = ch0_low_q;
        end else if (rd_idx == IDX_CH0_HIGH) begin
            nxt_rdata = ch0_high_q;
        end else if (rd_idx == IDX_CH1_LOW) begin
            nxt_rdata = ch1_low_q;
        end else if (rd_idx == IDX_CH1_HIGH) begin
            nxt_rdata = ch1_high_q;
        end else if (rd_idx == IDX_CONTROL) begin
            nxt_rdata = control_q;
        end else begin
            nxt_hit = 1'b0;
        end
    end

    // Registered read answer, valid the cycle after the strobe, else idle
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_ff <= `READ_IDLE;
            rd_hit_ff <= 1'b0;
        end else if (SFR_RD) begin
            rdata_ff <= nxt_rdata;
            rd_hit_ff <= nxt_hit;
        end else begin
            rdata_ff <= `READ_IDLE;
            rd_hit_ff <= 1'b0;
        end
    end

    assign SFR_RDATA = rdata_ff;
    assign SFR_RD_HIT = rd_hit_ff;

endmodule

// file: testbench/dual_dac_ctrl_props.sv
// Purpose: Port-level checks for the dual converter control block.
// Assumes: One-cycle register strobes on SYS_CLK, never read and write together.
// Notes: A shadow of the five registers predicts codes and read data.
`timescale 1ns/1ps
`include "dac_ctrl_consts.vh"

module dual_dac_ctrl_props (
    input wire SYS_CLK,
    input wire RST_N,
    input wire [7:0] SFR_ADDR,
    input wire [`BYTE_W-1:0] SFR_WDATA,
    input wire SFR_WR,
    input wire SFR_RD,
    input wire [`BYTE_W-1:0] SFR_RDATA,
    input wire SFR_RD_HIT,
    input wire [`CODE_W-1:0] CHAN0_CODE,
    input wire [`CODE_W-1:0] CHAN1_CODE,
    input wire CHAN0_SPAN_SELECT,
    input wire CHAN1_SPAN_SELECT,
    input wire CHAN0_POWER_ON,
    input wire CHAN1_POWER_ON,
    input wire CHAN0_OUT_EN,
    input wire CHAN1_OUT_EN,
    input wire CHAN0_FORCE_ZERO_N,
    input wire CHAN1_FORCE_ZERO_N
);
    reg [7:0] sh_ff [0:4];
    // Decode; F9..FD map to shadow slots 0..4
    wire hit = SFR_ADDR >= `ADDR_CH0_LOW && SFR_ADDR <= `ADDR_CONTROL;
    wire [2:0] idx = SFR_ADDR[2:0] - 3'h1;
    wire [7:0] ctl = sh_ff[4];
    wire [7:0] rsel = sh_ff[idx];
    wire wr_ctl = SFR_WR && SFR_ADDR == `ADDR_CONTROL;
    wire rel = wr_ctl && SFR_WDATA[2] && !ctl[2];
    wire im0 = SFR_WR && SFR_ADDR == `ADDR_CH0_LOW && ctl[2];
    wire im1 = SFR_WR && SFR_ADDR == `ADDR_CH1_LOW && ctl[2];
    wire upd = wr_ctl || im0 || im1;

    function automatic [11:0] cd(input m8, input [7:0] hi, input [7:0] lo);
        cd = m8 ? {lo, 4'h0} : {hi[3:0], lo};
    endfunction

    // Shadow registers; unmapped writes must never land
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < 5; i++) begin
                sh_ff[i] <= (i == 4) ? `RST_CONTROL : `RST_CODE_BYTE;
            end
        end else if (SFR_WR && hit) begin
            sh_ff[idx] <= SFR_WDATA;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    property p_span;
        wr_ctl |-> ##2 {CHAN1_SPAN_SELECT, CHAN0_SPAN_SELECT} == $past(SFR_WDATA[6:5], 2);
    endproperty
    a_span: assert property (p_span) else $error("span mismatch");
    property p_fzn;
        wr_ctl |-> ##2 {CHAN1_FORCE_ZERO_N, CHAN0_FORCE_ZERO_N} == $past(SFR_WDATA[4:3], 2);
    endproperty
    a_fzn: assert property (p_fzn) else $error("clear bit mismatch");
    property p_pwr;
        wr_ctl |-> ##2 {CHAN1_POWER_ON, CHAN0_POWER_ON} == $past(SFR_WDATA[1:0], 2);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power mismatch");
    property p_oe;
        {CHAN1_OUT_EN, CHAN0_OUT_EN} == {CHAN1_POWER_ON, CHAN0_POWER_ON}
            && {CHAN1_OUT_EN, CHAN0_OUT_EN} == $past(ctl[1:0]);
    endproperty
    a_oe: assert property (p_oe) else $error("output enable mismatch");
    property p_zero1;
        !CHAN1_FORCE_ZERO_N |-> CHAN1_CODE == `ZERO_CODE;
    endproperty
    a_zero1: assert property (p_zero1) else $error("ch1 not forced to zero");
    property p_zero0;
        !CHAN0_FORCE_ZERO_N |-> CHAN0_CODE == `ZERO_CODE;
    endproperty
    a_zero0: assert property (p_zero0) else $error("ch0 not forced to zero");
    property p_imm0;
        im0 ##1 !wr_ctl |-> ##1
            (!CHAN0_FORCE_ZERO_N || CHAN0_CODE == $past(cd(ctl[7], sh_ff[1], SFR_WDATA), 2));
    endproperty
    a_imm0: assert property (p_imm0) else $error("ch0 code wrong");
    property p_imm1;
        im1 ##1 !wr_ctl |-> ##1
            (!CHAN1_FORCE_ZERO_N || CHAN1_CODE == $past(cd(ctl[7], sh_ff[3], SFR_WDATA), 2));
    endproperty
    a_imm1: assert property (p_imm1) else $error("ch1 code wrong");
    property p_rel;
        rel ##1 !wr_ctl |-> ##1
            CHAN0_CODE == ($past(SFR_WDATA[3], 2) ?
                $past(cd(SFR_WDATA[7], sh_ff[1], sh_ff[0]), 2) : 12'h000)
            && CHAN1_CODE == ($past(SFR_WDATA[4], 2) ?
                $past(cd(SFR_WDATA[7], sh_ff[3], sh_ff[2]), 2) : 12'h000);
    endproperty
    a_rel: assert property (p_rel) else $error("sync release wrong");
    property p_hold;
        $changed({CHAN1_CODE, CHAN0_CODE}) |-> $past(upd, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved without cause");
    property p_rd;
        SFR_RD && hit |=> SFR_RD_HIT && SFR_RDATA == $past(rsel);
    endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
endmodule

bind dual_dac_ctrl dual_dac_ctrl_props dual_dac_ctrl_props_inst (.SYS_CLK, .RST_N, .SFR_ADDR,
    .SFR_WDATA, .SFR_WR, .SFR_RD, .SFR_RDATA, .SFR_RD_HIT, .CHAN0_CODE, .CHAN1_CODE,
    .CHAN0_SPAN_SELECT, .CHAN1_SPAN_SELECT, .CHAN0_POWER_ON, .CHAN1_POWER_ON,
    .CHAN0_OUT_EN, .CHAN1_OUT_EN, .CHAN0_FORCE_ZERO_N, .CHAN1_FORCE_ZERO_N);

// file: testbench/dual_dac_ctrl_tb_top.sv
// Purpose: Self-checking bench for the dual converter control block.
// Assumes: Inputs change on the falling edge; strobes held across back-to-back ops.
// Notes: A byte model of the registers predicts codes, levels and read data.
`timescale 1ns/1ps
`include "dac_ctrl_consts.vh"

module dual_dac_ctrl_tb_top;
    reg sys_clk;
    reg rst_n;
    reg [7:0] addr;
    reg [7:0] wdata;
    reg wr;
    reg rd;
    wire [7:0] rdata;
    wire rd_hit;
    wire [11:0] code0;
    wire [11:0] code1;
    wire [1:0] span;
    wire [1:0] pwr;
    wire [1:0] oe;
    wire [1:0] fzn;
    int n_mismatch;
    int comparisons;
    reg [7:0] m [0:4];
    reg [11:0] act [0:1];

    dual_dac_ctrl dual_dac_ctrl_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .SFR_ADDR(addr),
        .SFR_WDATA(wdata), .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .SFR_RD_HIT(rd_hit),
        .CHAN0_CODE(code0), .CHAN1_CODE(code1), .CHAN0_SPAN_SELECT(span[0]),
        .CHAN1_SPAN_SELECT(span[1]), .CHAN0_POWER_ON(pwr[0]), .CHAN1_POWER_ON(pwr[1]),
        .CHAN0_OUT_EN(oe[0]), .CHAN1_OUT_EN(oe[1]), .CHAN0_FORCE_ZERO_N(fzn[0]),
        .CHAN1_FORCE_ZERO_N(fzn[1]));

    // 250 MHz core clock
    always #2 sys_clk = ~sys_clk;

    function automatic [11:0] cd(input m8, input [7:0] hi, input [7:0] lo);
        cd = m8 ? {lo, 4'h0} : {hi[3:0], lo};
    endfunction

    task automatic chk(input string what, input [11:0] seen, input [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic mreset();
        for (int i = 0; i < 4; i++) m[i] = 8'h00;
        m[4] = 8'h04;
        act[0] = 12'h000;
        act[1] = 12'h000;
    endtask

    // Write one register; the model loads codes the way the outputs should
    task automatic wr_reg(input [7:0] a, input [7:0] d);
        reg s;
        s = m[4][2];
        wr = 1'b1;
        rd = 1'b0;
        addr = a;
        wdata = d;
        if (a >= 8'hf9 && a <= 8'hfd) m[a - 8'hf9] = d;
        if ((a == 8'hfd && d[2] && !s) || (s && a == 8'hf9)) act[0] = cd(m[4][7], m[1], m[0]);
        if ((a == 8'hfd && d[2] && !s) || (s && a == 8'hfb)) act[1] = cd(m[4][7], m[3], m[2]);
        @(negedge sys_clk);
    endtask

    task automatic rd_reg(input [7:0] a);
        reg hit;
        hit = a >= 8'hf9 && a <= 8'hfd;
        wr = 1'b0;
        rd = 1'b1;
        addr = a;
        @(negedge sys_clk);
        chk("read data", rdata, hit ? m[a - 8'hf9] : 8'h00);
        chk("read hit", rd_hit, hit);
    endtask

    task automatic idle(input int n);
        wr = 1'b0;
        rd = 1'b0;
        repeat (n) @(negedge sys_clk);
    endtask

    // Outputs settle one edge after the register state
    task automatic chk_out();
        idle(1);
        chk("code0", code0, m[4][3] ? act[0] : 12'h000);
        chk("code1", code1, m[4][4] ? act[1] : 12'h000);
        chk("span", span, m[4][6:5]);
        chk("power", pwr, m[4][1:0]);
        chk("out enable", oe, m[4][1:0]);
        chk("clear bits", fzn, m[4][4:3]);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Watchdog sized well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        reg [7:0] a;
        sys_clk = 1'b0;
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        void'($urandom(32'haef620b5));
        mreset();
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        // Power-on values, with unmapped neighbours on both sides
        for (int i = 8'hf8; i <= 8'hfe; i++) rd_reg(i[7:0]);
        chk_out();
        done("reset");
        // 12-bit immediate, high byte first with junk in its upper nibble
        // Reference span on both channels, with both channels powered and sync set
        wr_reg(8'hfd, 8'h1f);
        for (int c = 0; c < 2; c++) begin
            wr_reg(8'(8'hfa + 2 * c), 8'hf0 | 8'($urandom));
            wr_reg(8'(8'hf9 + 2 * c), 8'($urandom));
            chk_out();
        end
        wr_reg(8'hfa, 8'h0f);
        chk_out();
        done("immediate");
        // 8-bit mode places the low byte left aligned
        wr_reg(8'hfd, 8'h9f);
        wr_reg(8'hf9, 8'hff);
        wr_reg(8'hfb, 8'h01);
        chk_out();
        done("mode8");
        // Held update, then both channels move together on release
        wr_reg(8'hfd, 8'h1b);
        for (int i = 8'hf9; i <= 8'hfc; i++) wr_reg(i[7:0], 8'($urandom));
        chk_out();
        wr_reg(8'hfd, 8'h1f);
        chk_out();
        done("sync");
        // Back-to-back random traffic, unmapped addresses included
        repeat (400) begin
            a = 8'(8'hf7 + $urandom_range(0, 7));
            if ($urandom_range(0, 3) == 0) rd_reg(a);
            else wr_reg(a, 8'($urandom));
            if ($urandom_range(0, 5) == 0) chk_out();
        end
        done("random");
        // Reset in mid-run returns everything to power-on values
        rst_n = 1'b0;
        idle(2);
        rst_n = 1'b1;
        mreset();
        rd_reg(8'hfd);
        chk_out();
        done("second reset");
        stop_test();
    end
endmodule
